// [tb/rfal_limits_asserts.sv]
// Port checker for the frequency alarm limit block, bound to its top module.
`timescale 1ns/100ps
`default_nettype none

module rfal_limits_chk #(
  parameter N_REF = 14,
  parameter OFS_W = 16,
  parameter SEL_W = 4
) (
  input wire logic                   core_clk,
  input wire logic                   arst_n,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic [N_REF*OFS_W-1:0] meas_offset,
  input wire logic [N_REF-1:0]       meas_valid,
  input wire logic [N_REF-1:0]       soft_alarm,
  input wire logic [N_REF-1:0]       hard_alarm,
  input wire logic [N_REF-1:0]       ref_reject
);
  // Magnitude of reference 0 offset; one extra bit so the most negative value fits.
  wire signed [OFS_W:0] ofs0 = $signed(meas_offset[OFS_W-1:0]);
  wire        [OFS_W:0] mag0 = ofs0[OFS_W] ? -ofs0 : ofs0;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  property p_rdy_setup; psel && !penable |=> pready; endproperty
  a_rdy_setup: assert property (p_rdy_setup) else $error("pready late after setup");
  property p_rdy_one; pready |=> !pready; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("pready held too long");
  property p_err_rdy; pslverr |-> pready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  property p_rd_idle; !pready || pwrite |-> prdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("prdata not zero");
  property p_hold; ((hard_alarm ^ $past(hard_alarm)) & ~$past(meas_valid)) == '0; endproperty
  a_hold: assert property (p_hold) else $error("alarm moved without measurement");
  property p_rej; (ref_reject & ~$past(hard_alarm)) == '0; endproperty
  a_rej: assert property (p_rej) else $error("reject without hard alarm");
  // Largest limit is code 15, that is 16 steps of 3.81 ppm.
  property p_big; meas_valid[0] && mag0 > 6096 |=> hard_alarm[0] && soft_alarm[0]; endproperty
  a_big: assert property (p_big) else $error("large offset missed");
  property p_small; meas_valid[0] && mag0 <= 381 |=> !hard_alarm[0] && !soft_alarm[0];
  endproperty
  a_small: assert property (p_small) else $error("small offset flagged");
endmodule // rfal_limits_chk

bind rfal_limits rfal_limits_chk #(.N_REF(N_REF), .OFS_W(OFS_W), .SEL_W(SEL_W)) u_chk (
  .core_clk, .arst_n, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .meas_offset, .meas_valid, .soft_alarm, .hard_alarm, .ref_reject);

`default_nettype wire

// [tb/rfal_limits_tb.sv]
// Self-checking bench for the frequency alarm limit registers and monitors.
`timescale 1ns/100ps
`default_nettype none
`include "rfal_regs.vh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end

module rfal_limits_tb;
  logic         core_clk    = 1'b0;
  logic         arst_n      = 1'b0;
  logic         psel        = 1'b0;
  logic         penable     = 1'b0;
  logic         pwrite      = 1'b0;
  logic [11:0]  paddr       = 12'h000;
  logic [31:0]  pwdata      = 32'h0;
  logic [223:0] meas_offset = '0;
  logic [13:0]  meas_valid  = 14'h0;
  logic [3:0]   sel_ref     = 4'h0;
  logic         sel_ref_valid = 1'b0;
  wire  [31:0]  prdata;
  wire          pready, pslverr, irq;
  wire  [13:0]  soft_alarm, hard_alarm, ref_reject;
  int           n_errors = 0;
  int           total_checks = 0;

  // 25 MHz clock.
  always #20 core_clk = ~core_clk;

  rfal_limits uut (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .meas_offset, .meas_valid, .sel_ref, .sel_ref_valid,
    .soft_alarm, .hard_alarm, .ref_reject, .irq);

  // ------------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One APB transfer; pready and the read data are taken at the rising edge that completes it.
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    logic got;
    got = 1'b0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (int n = 0; n < 20 && !got; n++) begin
      @(posedge core_clk);
      if (pready === 1'b1) begin
        got = 1'b1;
        rd = prdata;
        err = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (!got) begin
      n_errors++;
      $display("wrong value pready expected 1 seen 0");
      close_out();
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0, r, e);
    `CHK("prdata", exp, r)
    `CHK("pslverr", exp_err, e)
  endtask

  // Pulse one measurement and look at both alarms in the cycle after.
  task automatic meas(input int i, input logic [15:0] off, input logic es, input logic eh);
    @(posedge core_clk);
    meas_offset[i*16 +: 16] <= off;
    meas_valid[i] <= 1'b1;
    @(posedge core_clk);
    meas_valid <= 14'h0;
    @(negedge core_clk);
    `CHK("soft_alarm", es, soft_alarm[i])
    `CHK("hard_alarm", eh, hard_alarm[i])
  endtask

  function automatic logic [15:0] lim(input int c);
    return 16'((c + 1) * `RFAL_STEP_CPPM);
  endfunction

  // ------------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    rd_chk(`RFAL_IDX_INPUT_LIM, 32'h23, 1'b0);
    rd_chk(`RFAL_IDX_SEL_LIM, 32'h23, 1'b0);
    rd_chk(10'h3ff, 32'h0, 1'b1);
    $display("test reset values done");
    // Soft code 10, hard code 5: hard limit below soft shows the nibble split.
    wr(`RFAL_IDX_INPUT_LIM, 32'ha5);
    rd_chk(`RFAL_IDX_INPUT_LIM, 32'ha5, 1'b0);
    meas(0, lim(5), 1'b0, 1'b0);
    meas(0, lim(5) + 16'h1, 1'b0, 1'b1);
    meas(0, lim(10) + 16'h1, 1'b1, 1'b1);
    meas(0, -(lim(5) + 16'h1), 1'b0, 1'b1);
    meas(0, 16'h8000, 1'b1, 1'b1);
    meas(0, 16'h0, 1'b0, 1'b0);
    $display("test common limits done");
    wr(`RFAL_IDX_SEL_LIM, 32'h71);
    rd_chk(`RFAL_IDX_SEL_LIM, 32'h71, 1'b0);
    sel_ref <= 4'h5;
    sel_ref_valid <= 1'b1;
    meas(5, lim(1) + 16'h1, 1'b0, 1'b1);
    meas(6, lim(1) + 16'h1, 1'b0, 1'b0);
    meas(5, lim(7) + 16'h1, 1'b1, 1'b1);
    $display("test selected limits done");
    wr(`RFAL_IDX_INPUT_LIM, 32'h00);
    meas(0, lim(0) + 16'h1, 1'b1, 1'b1);
    sel_ref_valid <= 1'b0;
    meas(5, lim(1) + 16'h1, 1'b1, 1'b1);
    sel_ref <= 4'hf;
    sel_ref_valid <= 1'b1;
    meas(5, lim(1) + 16'h1, 1'b1, 1'b1);
    $display("test limit change done");
    // Alarm events, interrupt and rejection.
    wr(`RFAL_IDX_IRQ_CLR, 32'hffffffff);
    rd_chk(`RFAL_IDX_IRQ_STAT, 32'h0, 1'b0);
    meas(0, 16'h0, 1'b0, 1'b0);
    wr(`RFAL_IDX_IRQ_EN, 32'h00010001);
    wr(`RFAL_IDX_REJECT_EN, 32'h1);
    rd_chk(`RFAL_IDX_IRQ_EN, 32'h00010001, 1'b0);
    rd_chk(`RFAL_IDX_REJECT_EN, 32'h1, 1'b0);
    rd_chk(`RFAL_IDX_IRQ_CLR, 32'h0, 1'b0);
    meas(0, lim(0) + 16'h1, 1'b1, 1'b1);
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    `CHK("irq", 1'b1, irq)
    `CHK("ref_reject", 1'b1, ref_reject[0])
    rd_chk(`RFAL_IDX_IRQ_STAT, 32'h00010001, 1'b0);
    rd_chk(`RFAL_IDX_ALARM_LVL, 32'h00210021, 1'b0);
    wr(`RFAL_IDX_IRQ_CLR, 32'h00010001);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    `CHK("irq", 1'b0, irq)
    wr(`RFAL_IDX_IRQ_EN, 32'h0);
    meas(0, 16'h0, 1'b0, 1'b0);
    meas(0, lim(0) + 16'h1, 1'b1, 1'b1);
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    `CHK("irq", 1'b0, irq)
    rd_chk(`RFAL_IDX_IRQ_STAT, 32'h00010001, 1'b0);
    // Hard half of the enable alone raises the interrupt for the hard status bit.
    wr(`RFAL_IDX_IRQ_EN, 32'h00010000);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    `CHK("irq", 1'b1, irq)
    wr(`RFAL_IDX_IRQ_CLR, 32'h00010000);
    wr(`RFAL_IDX_REJECT_EN, 32'h0);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    `CHK("irq", 1'b0, irq)
    `CHK("ref_reject", 1'b0, ref_reject[0])
    rd_chk(`RFAL_IDX_IRQ_STAT, 32'h00000001, 1'b0);
    $display("test events done");
    close_out();
  end
endmodule // rfal_limits_tb

`default_nettype wire

// [verilog/rfal_limits.v]
// Frequency alarm limit registers, per-reference monitors and APB slave.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "rfal_regs.vh"

module rfal_limits #(
  parameter N_REF = 14,
  parameter OFS_W = 16,
  parameter SEL_W = 4
) (
  input  wire                   core_clk,
  input  wire                   arst_n,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [11:0]            paddr,
  input  wire [31:0]            pwdata,
  output wire [31:0]            prdata,
  output wire                   pready,
  output wire                   pslverr,
  input  wire [N_REF*OFS_W-1:0] meas_offset,
  input  wire [N_REF-1:0]       meas_valid,
  input  wire [SEL_W-1:0]       sel_ref,
  input  wire                   sel_ref_valid,
  output wire [N_REF-1:0]       soft_alarm,
  output wire [N_REF-1:0]       hard_alarm,
  output wire [N_REF-1:0]       ref_reject,
  output wire                   irq
);

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  reg  [7:0]       input_lim_ff;
  reg  [7:0]       sel_lim_ff;
  reg  [N_REF-1:0] irq_en_soft_ff;
  reg  [N_REF-1:0] irq_en_hard_ff;
  reg  [N_REF-1:0] reject_en_ff;
  reg  [N_REF-1:0] ref_reject_ff;
  reg  [N_REF-1:0] soft_d_ff;
  reg  [N_REF-1:0] hard_d_ff;
  reg              irq_ff;
  reg  [31:0]      prdata_ff;
  reg              pready_ff;
  reg              pslverr_ff;
  reg  [31:0]      nxt_prdata;
  reg              nxt_pslverr;
  reg  [N_REF-1:0] clr_soft;
  reg  [N_REF-1:0] clr_hard;
  wire [9:0]       reg_idx;
  wire             setup_phase;
  wire             wr_done;
  wire [N_REF-1:0] soft_rise;
  wire [N_REF-1:0] hard_rise;
  wire [N_REF-1:0] soft_stat;
  wire [N_REF-1:0] hard_stat;
  wire [N_REF-1:0] soft_alarm_w;
  wire [N_REF-1:0] hard_alarm_w;
  wire [31:0]      alarm_lvl;
  wire [31:0]      irq_stat;

  // Word index; the two low address bits only select a byte and are ignored.
  assign reg_idx     = paddr[11:2];
  assign setup_phase = psel & ~penable;
  assign wr_done     = psel & penable & pready_ff & pwrite;

  // ----------------------------------------------------------------------------
  // Per-reference monitors
  // ----------------------------------------------------------------------------
  // The selected reference swaps the common limits for its own pair; all
  // others keep the common pair. A selection beyond the last reference
  // matches nothing, so every monitor then uses the common limits.
  genvar i;
  generate
    for (i = 0; i < N_REF; i = i + 1) begin : g_ref
      wire       is_sel;
      wire [3:0] soft_code;
      wire [3:0] hard_code;

      assign is_sel = sel_ref_valid & ({{(32-SEL_W){1'b0}}, sel_ref} == i);
      assign soft_code = is_sel ? sel_lim_ff[`RFAL_SOFT_MSB:`RFAL_SOFT_LSB]
                                : input_lim_ff[`RFAL_SOFT_MSB:`RFAL_SOFT_LSB];
      assign hard_code = is_sel ? sel_lim_ff[`RFAL_HARD_MSB:`RFAL_HARD_LSB]
                                : input_lim_ff[`RFAL_HARD_MSB:`RFAL_HARD_LSB];

      rfal_offset_cmp #(
        .OFS_W(OFS_W)
      ) u_cmp (
        .core_clk    (core_clk),
        .arst_n      (arst_n),
        .offset      (meas_offset[i*OFS_W +: OFS_W]),
        .offset_valid(meas_valid[i]),
        .soft_code   (soft_code),
        .hard_code   (hard_code),
        .soft_alarm  (soft_alarm_w[i]),
        .hard_alarm  (hard_alarm_w[i])
      );
    end
  endgenerate

  assign soft_alarm = soft_alarm_w;
  assign hard_alarm = hard_alarm_w;

  // ----------------------------------------------------------------------------
  // Alarm edge detection
  // ----------------------------------------------------------------------------
  // Only the rising edge of an alarm is an event; a standing alarm does not
  // keep re-arming the interrupt after software has cleared it.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_d_ff <= {N_REF{1'b0}};
      hard_d_ff <= {N_REF{1'b0}};
    end else begin
      soft_d_ff <= soft_alarm_w;
      hard_d_ff <= hard_alarm_w;
    end
  end

  assign soft_rise = soft_alarm_w & ~soft_d_ff;
  assign hard_rise = hard_alarm_w & ~hard_d_ff;

  // ----------------------------------------------------------------------------
  // Reference rejection
  // ----------------------------------------------------------------------------
  // A hard alarm rejects the reference only where software allowed it; soft
  // alarms are warnings and never reject.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_reject_ff <= {N_REF{1'b0}};
    end else begin
      ref_reject_ff <= hard_alarm_w & reject_en_ff;
    end
  end

  assign ref_reject = ref_reject_ff;

  // ----------------------------------------------------------------------------
  // Sticky event status and interrupt
  // ----------------------------------------------------------------------------
  // Clear strobes come from a completed write to the clear register.
  always @* begin
    clr_soft = {N_REF{1'b0}};
    clr_hard = {N_REF{1'b0}};
    if (wr_done && reg_idx == `RFAL_IDX_IRQ_CLR) begin
      clr_soft = pwdata[N_REF-1:0];
      clr_hard = pwdata[`RFAL_HARD_FLD_LSB +: N_REF];
    end
  end

  rfal_sticky #(
    .W(N_REF)
  ) u_soft_stat (
    .core_clk(core_clk),
    .arst_n  (arst_n),
    .set_in  (soft_rise),
    .clr_in  (clr_soft),
    .status  (soft_stat)
  );

  rfal_sticky #(
    .W(N_REF)
  ) u_hard_stat (
    .core_clk(core_clk),
    .arst_n  (arst_n),
    .set_in  (hard_rise),
    .clr_in  (clr_hard),
    .status  (hard_stat)
  );

  // The enable register shares the status layout: soft low, hard high.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (|(soft_stat & irq_en_soft_ff)) | (|(hard_stat & irq_en_hard_ff));
    end
  end

  assign irq = irq_ff;

  // ----------------------------------------------------------------------------
  // Read views
  // ----------------------------------------------------------------------------
  assign alarm_lvl = {{(16-N_REF){1'b0}}, hard_alarm_w,
                      {(16-N_REF){1'b0}}, soft_alarm_w};
  assign irq_stat  = {{(16-N_REF){1'b0}}, hard_stat,
                      {(16-N_REF){1'b0}}, soft_stat};

  // ----------------------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------------------
  // Limits feed the comparators directly, so a write counts from the next
  // measurement onward with no monitor restart.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      input_lim_ff <= `RFAL_INPUT_LIM_RST;
      sel_lim_ff   <= `RFAL_SEL_LIM_RST;
      irq_en_soft_ff <= {N_REF{1'b0}};
      irq_en_hard_ff <= {N_REF{1'b0}};
      reject_en_ff <= {N_REF{1'b0}};
    end else if (wr_done) begin
      if (reg_idx == `RFAL_IDX_INPUT_LIM) begin
        input_lim_ff <= pwdata[7:0];
      end else if (reg_idx == `RFAL_IDX_SEL_LIM) begin
        sel_lim_ff <= pwdata[7:0];
      end else if (reg_idx == `RFAL_IDX_IRQ_EN) begin
        irq_en_soft_ff <= pwdata[N_REF-1:0];
        irq_en_hard_ff <= pwdata[`RFAL_HARD_FLD_LSB +: N_REF];
      end else if (reg_idx == `RFAL_IDX_REJECT_EN) begin
        reject_en_ff <= pwdata[N_REF-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // APB read mux and decode
  // ----------------------------------------------------------------------------
  // Decoded in the setup cycle so the answer is ready at the first access
  // cycle. Unmapped words read zero and report an error. Read-only words
  // ignore writes without error.
  always @* begin
    nxt_prdata  = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    if (reg_idx == `RFAL_IDX_INPUT_LIM) begin
      nxt_prdata = {24'h00_0000, input_lim_ff};
    end else if (reg_idx == `RFAL_IDX_SEL_LIM) begin
      nxt_prdata = {24'h00_0000, sel_lim_ff};
    end else if (reg_idx == `RFAL_IDX_ALARM_LVL) begin
      nxt_prdata = alarm_lvl;
    end else if (reg_idx == `RFAL_IDX_IRQ_STAT) begin
      nxt_prdata = irq_stat;
    end else if (reg_idx == `RFAL_IDX_IRQ_CLR) begin
      nxt_prdata = 32'h0000_0000;
    end else if (reg_idx == `RFAL_IDX_IRQ_EN) begin
      nxt_prdata = {{(16-N_REF){1'b0}}, irq_en_hard_ff,
                    {(16-N_REF){1'b0}}, irq_en_soft_ff};
    end else if (reg_idx == `RFAL_IDX_REJECT_EN) begin
      nxt_prdata = {{(32-N_REF){1'b0}}, reject_en_ff};
    end else begin
      nxt_pslverr = 1'b1;
    end
    if (pwrite) begin
      nxt_prdata = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------------
  // APB response flops
  // ----------------------------------------------------------------------------
  // Ready rises on the setup edge and falls after the access edge, giving a
  // zero-wait transfer; holding it registered keeps the outputs glitch free.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (setup_phase) begin
      prdata_ff  <= nxt_prdata;
      pready_ff  <= 1'b1;
      pslverr_ff <= nxt_pslverr;
    end else begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

endmodule // rfal_limits

`default_nettype wire

// [verilog/rfal_offset_cmp.v]
// One frequency monitor comparator: limit code to ppm and symmetric compare.
`timescale 1ns/100ps
`default_nettype none
`include "rfal_regs.vh"

module rfal_offset_cmp #(
  parameter OFS_W = 16
) (
  input  wire             core_clk,
  input  wire             arst_n,
  input  wire [OFS_W-1:0] offset,
  input  wire             offset_valid,
  input  wire [3:0]       soft_code,
  input  wire [3:0]       hard_code,
  output wire             soft_alarm,
  output wire             hard_alarm
);

  reg            soft_ff;
  reg            hard_ff;
  wire [OFS_W:0] mag;
  wire [13:0]    soft_lim;
  wire [13:0]    hard_lim;
  wire [OFS_W:0] soft_lim_x;
  wire [OFS_W:0] hard_lim_x;

  // Magnitude is one bit wider so the most negative offset still compares.
  assign mag = offset[OFS_W-1] ? ({1'b0, ~offset} + {{OFS_W{1'b0}}, 1'b1})
                               : {1'b0, offset};

  // Limit in hundredths of a ppm is (code + 1) times the step.
  assign soft_lim = {5'h00, `RFAL_STEP_CPPM} * {9'h000, 1'b0, soft_code}
                  + {5'h00, `RFAL_STEP_CPPM};
  assign hard_lim = {5'h00, `RFAL_STEP_CPPM} * {9'h000, 1'b0, hard_code}
                  + {5'h00, `RFAL_STEP_CPPM};
  assign soft_lim_x = {{(OFS_W-13){1'b0}}, soft_lim};
  assign hard_lim_x = {{(OFS_W-13){1'b0}}, hard_lim};

  assign soft_alarm = soft_ff;
  assign hard_alarm = hard_ff;

  // ----------------------------------------------------------------------------
  // Each new measurement is judged against the codes present right now.
  // ----------------------------------------------------------------------------
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_ff <= 1'b0;
      hard_ff <= 1'b0;
    end else if (offset_valid) begin
      soft_ff <= (mag > soft_lim_x);
      hard_ff <= (mag > hard_lim_x);
    end
  end

endmodule // rfal_offset_cmp

`default_nettype wire

// [verilog/rfal_regs.vh]
// Register offsets, field layouts, reset values and scaling for the alarm limit bank.
`ifndef RFAL_REGS_VH
`define RFAL_REGS_VH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define RFAL_IDX_INPUT_LIM  10'h049
`define RFAL_IDX_SEL_LIM    10'h04a
`define RFAL_IDX_ALARM_LVL  10'h050
`define RFAL_IDX_IRQ_STAT   10'h051
`define RFAL_IDX_IRQ_CLR    10'h052
`define RFAL_IDX_IRQ_EN     10'h053
`define RFAL_IDX_REJECT_EN  10'h054

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define RFAL_SOFT_MSB       7
`define RFAL_SOFT_LSB       4
`define RFAL_HARD_MSB       3
`define RFAL_HARD_LSB       0
`define RFAL_HARD_FLD_LSB   16
`define RFAL_INPUT_LIM_RST  8'h23
`define RFAL_SEL_LIM_RST    8'h23

// ----------------------------------------------------------------------------
// Scaling: offsets are in hundredths of a ppm, one step is 3.81 ppm
// ----------------------------------------------------------------------------
`define RFAL_STEP_CPPM      9'h17d

`endif

// [verilog/rfal_sticky.v]
// Sticky event bits with write-one-to-clear, set winning over clear.
`timescale 1ns/100ps
`default_nettype none

module rfal_sticky #(
  parameter W = 14
) (
  input  wire         core_clk,
  input  wire         arst_n,
  input  wire [W-1:0] set_in,
  input  wire [W-1:0] clr_in,
  output wire [W-1:0] status
);

  reg [W-1:0] status_ff;

  assign status = status_ff;

  // ----------------------------------------------------------------------------
  // One flop per bit; an event in the clear cycle must not be lost.
  // ----------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          status_ff[i] <= 1'b0;
        end else begin
          status_ff[i] <= set_in[i] | (status_ff[i] & ~clr_in[i]);
        end
      end
    end
  endgenerate

endmodule // rfal_sticky

`default_nettype wire
